// ===== design/cca_defines.vh
// constants for the convolver cascade alignment block
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH
// initialization word field positions
`define CCA_INIT_W        9
`define CCA_MODE_BIT      0
`define CCA_DLY_LO        1
`define CCA_DLY_HI        2
`define CCA_SHF_LO        7
`define CCA_SHF_HI        8
`define CCA_INIT_RST      9'h000
// data widths
`define CCA_PIX_W         8
`define CCA_COEF_W        8
`define CCA_CAS_W         16
`define CCA_RES_W         20
`define CCA_PROD_W        16
// shift codes
`define CCA_SHF_0         2'h0
`define CCA_SHF_2         2'h1
`define CCA_SHF_4         2'h2
// fifo shape
`define CCA_FIFO_DEPTH    8
`define CCA_FIFO_AW       3
`endif

// ===== design/cca_fifo.v
// parameterised valid/ready fifo used in the result path
`timescale 1ns/1ns
module cca_fifo #(
   parameter WIDTH = 20,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire [WIDTH-1:0] in_data_i,
   input  wire             in_valid_i,
   output wire             in_ready_o,
   output wire [WIDTH-1:0] out_data_o,
   output wire             out_valid_o,
   input  wire             out_ready_i
);
   // ==========================================================
   // storage and pointers
   reg [WIDTH-1:0] mem [0:DEPTH-1];   // word store
   reg [AW-1:0]    wr_q;              // write pointer
   reg [AW-1:0]    rd_q;              // read pointer
   reg [AW:0]      cnt_q;             // fill level
   wire            push;
   wire            pop;
   assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
   assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;
   assign out_data_o = mem[rd_q];
   // ==========================================================
   // memory write, no reset needed on data
   always @(posedge clk_i) begin
      if (push) begin
         mem[wr_q] <= in_data_i;
      end
   end
   // pointer and level update
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
         end
         // simultaneous push and pop keeps the level
         if (push & ~pop) begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

// ===== design/cca_top.v
// cascade alignment datapath of a 3x3 convolver
`timescale 1ns/1ns
`include "cca_defines.vh"
module cca_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [7:0]  pixel_in_i,       // pixel_in stream
   input  wire        pixel_valid_i,    // pixel present this cycle
   output reg         pixel_ready_o,    // pixel accepted
   input  wire [15:0] cascade_in_i,     // cascade_in bus
   input  wire [71:0] coef_i,           // nine coefficients, a in low byte
   input  wire [8:0]  init_data_i,      // initialization word to write
   input  wire        load_strobe_n_i,  // low writes init word at the edge
   output reg  [19:0] result_out_o,     // result_out
   output reg         result_valid_o,   // result present
   input  wire        result_ready_i,   // sink may stall
   output reg  [8:0]  init_o            // current initialization word
);
   // ==========================================================
   // configuration
   reg  [8:0]  init_q;                 // initialization register
   wire        cas_mode;
   wire [1:0]  dly_sel;
   wire [1:0]  shf_sel;
   assign cas_mode = init_q[`CCA_MODE_BIT];
   assign dly_sel  = init_q[`CCA_DLY_HI:`CCA_DLY_LO];
   assign shf_sel  = init_q[`CCA_SHF_HI:`CCA_SHF_LO];
   // write lands on the sampling edge even mid-frame
   // the strobe is a level: each edge it is low reloads the word,
   // so a long strobe simply writes the same value again
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         init_q <= `CCA_INIT_RST;
      end else if (!load_strobe_n_i) begin
         init_q <= init_data_i;
      end
   end
   // ==========================================================
   // stall: pipeline advances only while fifo has room
   // a refused pixel is simply not taken and gets no acknowledge;
   // the taps, window and cascade word below move only when a pixel is taken
   wire        fifo_ready;             // fifo stores fewer than depth words
   wire        room;                   // fifo also fits the result in flight
   wire        adv;                    // pixel taken at this edge
   assign adv = pixel_valid_i & fifo_ready & room;
   // ==========================================================
   // programmable pixel input delay, 0..3 stages
   reg  [7:0]  dly_q [0:2];            // delay taps
   reg  [7:0]  pix_d;                  // delayed pixel
   integer     i;                      // window reset index
   // taps move only with taken pixels, so a stall keeps them in step
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dly_q[0] <= 8'h00;
         dly_q[1] <= 8'h00;
         dly_q[2] <= 8'h00;
      end else if (adv) begin
         dly_q[0] <= pixel_in_i;
         dly_q[1] <= dly_q[0];
         dly_q[2] <= dly_q[1];
      end
   end
   // tap select, code 2 and 3 give the cascade alignment delays
   // code 0 passes the pin straight through, no register in the way
   always @* begin
      case (dly_sel)
         2'h0:    pix_d = pixel_in_i;
         2'h1:    pix_d = dly_q[0];
         2'h2:    pix_d = dly_q[1];
         2'h3:    pix_d = dly_q[2];
         default: pix_d = pixel_in_i;
      endcase
   end
   // ==========================================================
   // cascade input scaling; upstream already picked its slice
   // the left shift undoes the upstream slice offset, so the word
   // lands back on the bit weights of the upstream result
   reg  [19:0] cas_shf;                // aligned cascade word
   always @* begin
      case (shf_sel)
         `CCA_SHF_0: cas_shf = {4'h0, cascade_in_i};
         `CCA_SHF_2: cas_shf = {2'h0, cascade_in_i, 2'h0};
         `CCA_SHF_4: cas_shf = {cascade_in_i, 4'h0};
         default:    cas_shf = {4'h0, cascade_in_i};
      endcase
   end
   // ==========================================================
   // window of three rows by three columns
   // row 0 = bottom (local pixel), rows 1,2 from cascade in cascade mode
   // the input delay acts on the local row only; rows fed from
   // external buffers must be aligned by whatever drives them
   // a mode change does not clear the upper rows: stale words
   // leave the window after three taken pixels
   reg  [7:0]  win_q [0:8];            // pixel window, index row*3+col
   reg  [7:0]  row1_in;
   reg  [7:0]  row2_in;
   always @* begin
      // without external buffers upper rows are fed with zero
      if (cas_mode) begin
         row1_in = cascade_in_i[7:0];
         row2_in = cascade_in_i[15:8];
      end else begin
         row1_in = 8'h00;
         row2_in = 8'h00;
      end
   end
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (i = 0; i < 9; i = i + 1) begin
            win_q[i] <= 8'h00;
         end
      end else if (adv) begin
         win_q[0] <= pix_d;
         win_q[1] <= win_q[0];
         win_q[2] <= win_q[1];
         win_q[3] <= row1_in;
         win_q[4] <= win_q[3];
         win_q[5] <= win_q[4];
         win_q[6] <= row2_in;
         win_q[7] <= win_q[6];
         win_q[8] <= win_q[7];
      end
   end
   // ==========================================================
   // nine unsigned products summed in one cycle
   // nine 16-bit products need at most 20 bits, so the local sum
   // never wraps; only the cascade add below can
   reg  [19:0] sum;                    // local sum of products
   reg  [15:0] prod;                   // one product
   integer     n;                      // product index, own to this process
   always @* begin
      sum  = 20'h00000;
      prod = 16'h0000;
      for (n = 0; n < 9; n = n + 1) begin
         prod = win_q[n] * coef_i[n*8 +: 8];
         sum  = sum + {4'h0, prod};
      end
   end
   // chained mode: add aligned upstream partial sum
   // cas_q is caught with the taken pixel, so it pairs with that window
   reg  [19:0] res_d;                  // result before fifo
   reg         res_v_q;                // window holds fresh data
   reg  [19:0] cas_q;                  // cascade word aligned to window
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cas_q   <= 20'h00000;
         res_v_q <= 1'b0;
      end else begin
         if (adv) begin
            cas_q <= cas_shf;
         end
         res_v_q <= adv;
      end
   end
   always @* begin
      if (cas_mode) begin
         res_d = sum;
      end else begin
         res_d = sum + cas_q;
      end
   end
   // ==========================================================
   // result fifo; its full flag stalls the pixel intake
   // depth 8 absorbs short sink stalls without stopping the stream
   wire [19:0] f_data;
   wire        f_valid;
   wire        f_pop;
   cca_fifo #(
      .WIDTH (`CCA_RES_W),
      .DEPTH (`CCA_FIFO_DEPTH),
      .AW    (`CCA_FIFO_AW)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_data_i   (res_d),
      .in_valid_i  (res_v_q),
      .in_ready_o  (fifo_ready),
      .out_data_o  (f_data),
      .out_valid_o (f_valid),
      .out_ready_i (f_pop)
   );
   // pop when the output register is empty or being emptied
   assign f_pop = f_valid & (~result_valid_o | result_ready_i);
   // ==========================================================
   // fifo level mirror: stored words plus the result in flight
   // the fifo's own ready flag looks at stored words only, so a pixel
   // taken while the last slot fills would have its result refused a
   // cycle later and lost; counting the word in flight closes that gap
   // at the price of one idle intake cycle when the fifo is nearly full
   reg  [3:0]  lvl_q;                  // words held by the fifo
   wire [3:0]  lvl_room;               // held words plus the one in flight
   assign lvl_room = lvl_q + {3'h0, res_v_q};
   assign room     = (lvl_room < 4'h8);           // 4'h8 is the fifo depth
   // push is res_v_q itself: the room check keeps the fifo from refusing
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lvl_q <= 4'h0;
      end else if (res_v_q & ~f_pop) begin
         lvl_q <= lvl_q + 4'h1;                   // push only
      end else if (f_pop & ~res_v_q) begin
         lvl_q <= lvl_q - 4'h1;                   // pop only
      end
   end
   // ==========================================================
   // registered outputs
   // result_valid_o stands until the sink takes the word
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         result_out_o   <= 20'h00000;
         result_valid_o <= 1'b0;
         pixel_ready_o  <= 1'b0;
         init_o         <= `CCA_INIT_RST;
      end else begin
         if (f_pop) begin
            result_out_o   <= f_data;
            result_valid_o <= 1'b1;
         end else if (result_ready_i) begin
            result_valid_o <= 1'b0;
         end
         pixel_ready_o <= adv;
         init_o        <= init_q;
      end
   end
endmodule

// ===== tb/cca_top_sva.sv
// port checker for the cascade alignment top
`timescale 1ns/1ns
module cca_top_sva (
   input wire        clk_i,
   input wire        rst_i,
   input wire        pixel_valid_i,
   input wire        pixel_ready_o,
   input wire        load_strobe_n_i,
   input wire [8:0]  init_data_i,
   input wire [19:0] result_out_o,
   input wire        result_valid_o,
   input wire        result_ready_i,
   input wire [8:0]  init_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // stream handshake
   property p_ack; pixel_ready_o |-> $past(pixel_valid_i); endproperty
   a_ack:
      assert property (p_ack) else $error("ack without pixel");
   property p_fill; pixel_ready_o |-> ##[1:2] result_valid_o; endproperty
   a_fill:
      assert property (p_fill) else $error("taken pixel gave no result");
   property p_hold;
      result_valid_o && !result_ready_i |=> result_valid_o && $stable(result_out_o);
   endproperty
   a_hold:
      assert property (p_hold) else $error("result dropped under stall");
   property p_fall; $fell(result_valid_o) |-> $past(result_ready_i); endproperty
   a_fall:
      assert property (p_fall) else $error("result left unaccepted");
   // ==========
   // init word
   property p_load; !load_strobe_n_i |-> ##2 init_o == $past(init_data_i, 2); endproperty
   a_load:
      assert property (p_load) else $error("init word not loaded");
   property p_keep; $past(load_strobe_n_i, 2) |-> $stable(init_o); endproperty
   a_keep:
      assert property (p_keep) else $error("init word changed unasked");
   c_take: cover property (pixel_ready_o ##1 pixel_ready_o);
   c_stall: cover property (result_valid_o && !result_ready_i [*3]);
   c_load: cover property (!load_strobe_n_i);
endmodule
bind cca_top cca_top_sva chk (.clk_i, .rst_i, .pixel_valid_i, .pixel_ready_o,
   .load_strobe_n_i, .init_data_i, .result_out_o, .result_valid_o,
   .result_ready_i, .init_o);

// ===== tb/cca_upstream.sv
// upstream convolver model driving the cascade bus
`timescale 1ns/1ns
module cca_upstream (
   input  wire [19:0] up_result_i,
   input  wire [1:0]  slice_i,
   output wire [15:0] cascade_o
);
   // only 16 of the 20 result bits travel downstream
   assign cascade_o = 16'(up_result_i >> {slice_i, 1'b0});
endmodule

// ===== tb/tb.sv
// self-checking bench for the cascade alignment block
`timescale 1ns/1ns
module tb;
   reg  clk_i = 1'b0, rst_i = 1'b1, pixel_valid_i = 1'b0;
   reg  load_strobe_n_i = 1'b1, result_ready_i = 1'b0;
   reg  [7:0]  pixel_in_i = 8'h00, k0, k1, k2, pp;
   reg  [19:0] up_res = 20'h00000;
   reg  [1:0]  slice = 2'h0;
   reg  [71:0] coef_i = 72'h0;
   reg  [8:0]  init_data_i = 9'h000, cfg = 9'h000;
   reg  [15:0] pc;
   wire [15:0] cascade_in_i;
   wire [19:0] result_out_o;
   wire        pixel_ready_o, result_valid_o;
   wire [8:0]  init_o;
   integer     num_errors = 0, cmp_count = 0, i, t, stall;
   int         raw[$], pdq[$], c1q[$], c2q[$], expq[$];
   cca_upstream up (.up_result_i(up_res), .slice_i(slice), .cascade_o(cascade_in_i));
   cca_top uut (.clk_i, .rst_i, .pixel_in_i, .pixel_valid_i, .pixel_ready_o,
      .cascade_in_i, .coef_i, .init_data_i, .load_strobe_n_i, .result_out_o,
      .result_valid_o, .result_ready_i, .init_o);
   initial forever #10 clk_i = ~clk_i;
   // ==========
   // reference model, one step per taken pixel
   function int s3(int q[$]);
      s3 = 0;
      foreach (q[j]) if (j < 3) s3 += q[j];
   endfunction
   task automatic take(input int p, input int c);
      int e;
      raw.push_front(p);
      pdq.push_front(raw.size() > cfg[2:1] ? raw[cfg[2:1]] : 0);
      c1q.push_front(c & 255);
      c2q.push_front(c >> 8);
      e = k0 * s3(pdq);
      if (cfg[0]) e += k1 * s3(c1q) + k2 * s3(c2q);
      else e += c << (cfg[8:7] == 1 ? 2 : cfg[8:7] == 2 ? 4 : 0);
      expq.push_back(e & 20'hfffff);
      if (raw.size() > 4) void'(raw.pop_back());
   endtask
   task chk(input [19:0] got, input [19:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task chk_init(input [8:0] got, input [8:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t init word %h expected %h", $time, got, exp);
      end
   endtask
   task summarize;
      if (num_errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ack names the pixel offered one edge earlier
   always @(posedge clk_i) begin
      if (!rst_i) begin
         if (pixel_ready_o) take(pp, pc);
         if (result_valid_o && result_ready_i)
            chk(result_out_o, expq.size() ? expq.pop_front() : 20'hxxxxx);
      end
      pp = pixel_in_i;
      pc = cascade_in_i;
   end
   // ==========
   // stimulus
   task run(input int n);
      repeat (n) begin
         @(posedge clk_i);
         pixel_valid_i <= ($urandom % 8) != 0;
         pixel_in_i <= 8'($urandom);
         up_res <= 20'($urandom);
         result_ready_i <= stall ? ($urandom % 4) == 0 : ($urandom % 4) != 0;
      end
   endtask
   task drain;
      @(posedge clk_i);
      pixel_valid_i <= 1'b0;
      result_ready_i <= 1'b1;
      t = 0;
      repeat (3) @(posedge clk_i);
      while (expq.size() != 0 && t < 200) begin
         @(posedge clk_i);
         t++;
      end
      if (expq.size() != 0) begin
         num_errors++;
         $display("[ERR] %0t results missing", $time);
         summarize;
      end
   endtask
   // writes land while the stream pauses, then it resumes
   task cfg_write(input [8:0] w);
      @(posedge clk_i);
      pixel_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      {k2, k1, k0} = 24'($urandom);
      cfg = w;
      load_strobe_n_i <= 1'b0;
      init_data_i <= w;
      coef_i <= {{3{k2}}, {3{k1}}, {3{k0}}};
      slice <= w[8:7] == 2'h3 ? 2'h0 : w[8:7];
      repeat (2) @(posedge clk_i);
      load_strobe_n_i <= 1'b1;
      #1 chk_init(init_o, w);
   endtask
   initial begin
      void'($urandom(32'h87c3));
      for (i = 0; i < 32; i++) begin
         if (i % 4 == 0) begin
            if (i != 0) drain;
            rst_i <= 1'b1;
            repeat (12) @(posedge clk_i);
            rst_i <= 1'b0;
            raw.delete();
            pdq.delete();
            c1q.delete();
            c2q.delete();
         end
         stall = i % 3 == 0;
         cfg_write({i[3:2], 4'h0, i[1:0], i[4]});
         run(40);
      end
      drain;
      summarize;
   end
endmodule
